// *** dv/serial_flash_command_front_end_tb_top.sv ***
// testbench of the serial flash command front end
`timescale 1ns/10ps
`default_nettype none
`include "flash_fe_params.svh"

module serial_flash_command_front_end_tb_top
    import flash_fe_pkg::*;
;
    localparam int         AW      = 10;
    localparam int         SW      = 6;
    localparam logic [7:0] IDB [3] = '{8'hA5, 8'h3C, 8'h5A};  // arbitrary values
    localparam logic [7:0] PAT [4] = '{8'h96, 8'h3C, 8'hE1, 8'h0F};

    logic          clk     = 1'b0;
    logic          srst    = 1'b1;
    logic          op_req  = 1'b0;
    logic [1:0]    op_kind = 2'h3;
    logic [AW-1:0] op_addr = '0;
    logic [7:0]    op_data = 8'h00;
    wire logic     sclk, cs_n, si, so, so_oe, op_ack, op_refused, busy, write_enable_latch;
    int            err_count = 0;
    int            cmp_count = 0;
    logic [7:0]    mem [0:(1<<AW)-1];

    always #12.5 clk = ~clk;

    spi_host_model host (.sclk_out (sclk), .cs_n_out (cs_n), .si_out (si), .so_in (so),
                         .so_oe_in (so_oe));

    serial_flash_command_front_end #(.ADDR_W (AW), .SECT_W (SW), .ID_MAKER (IDB[0]),
        .ID_TYPE (IDB[1]), .ID_CAP (IDB[2])) dut (
        .clk_in (clk), .srst_in (srst), .sclk_in (sclk), .cs_n_in (cs_n), .si_in (si),
        .so_out (so), .so_oe_out (so_oe), .op_req_in (op_req), .op_kind_in (op_kind),
        .op_addr_in (op_addr), .op_data_in (op_data), .op_ack_out (op_ack),
        .op_refused_out (op_refused), .busy_out (busy), .wel_out (write_enable_latch));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : give_verdict

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic latch_op(input logic [7:0] opc, input int extra, input logic exp_wel);
        logic [7:0] rx, oe;
        host.frame_begin();
        host.xfer(8, opc, rx, oe);
        if (extra > 0)
            host.xfer(extra, 8'hFF, rx, oe);
        host.frame_end();
        tick(8);
        chk("write latch", exp_wel, write_enable_latch);
    endtask : latch_op

    task automatic core_op(input op_kind_t k, input logic [AW-1:0] a, input logic [7:0] d,
                           input logic exp_ack, input int exp_busy);
        int n;
        @(posedge clk);
        op_req  <= 1'b1;
        op_kind <= k;
        op_addr <= a;
        op_data <= d;
        @(negedge clk);
        chk("op ack", exp_ack, op_ack);
        chk("op refused", !exp_ack, op_refused);
        @(posedge clk);
        op_req <= 1'b0;
        n = 0;
        @(negedge clk);
        while (busy === 1'b1 && n < 5000)
        begin
            @(negedge clk);
            n++;
        end
        if (exp_ack)
        begin
            chk("busy cycles", exp_busy, n);
            chk("latch after op", 1'b0, write_enable_latch);
            for (int i = 0; i < (1 << AW); i++)
                if (k == OPK_BULK || (k == OPK_SECTOR && (i >> SW) == (a >> SW)))
                    mem[i] = 8'hFF;
                else if (k == OPK_PROGRAM && i == a)
                    mem[i] = mem[i] & d;
        end
    endtask : core_op

    task automatic rd(input logic [7:0] opc, input logic [AW-1:0] a, input int nb,
                      input logic exp_out, input int tail);
        logic [7:0]  rx, oe, e;
        logic [23:0] adr;
        adr = 24'(a);
        host.frame_begin();
        host.xfer(8, opc, rx, oe);
        if (opc != `OPC_ID_READ)
            for (int i = 2; i >= 0; i--)
                host.xfer(8, adr[8*i +: 8], rx, oe);
        if (opc == `OPC_FAST_READ)
            host.xfer(8, 8'h00, rx, oe);
        for (int k = 0; k < nb; k++)
        begin
            e = (opc == `OPC_ID_READ) ? IDB[k % 3] : mem[AW'(a + k)];
            host.xfer(8, 8'h5A, rx, oe);
            chk("so enable", exp_out ? 8'hFF : 8'h00, oe);
            if (exp_out)
                chk("read byte", e, rx);
        end
        if (tail > 0)
            host.xfer(tail, 8'hA5, rx, oe);
        host.frame_end();
        chk("so enable idle", 1'b0, so_oe);
    endtask : rd

    initial
    begin
        #1000000;
        err_count++;
        $display("BAD watchdog expected finish seen timeout");
        give_verdict();
    end

    initial
    begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        tick(2);
        chk("latch reset", 1'b0, write_enable_latch);
        chk("busy reset", 1'b0, busy);
        chk("so enable reset", 1'b0, so_oe);
        core_op(OPK_PROGRAM, 0, 8'h00, 1'b0, 0);
        latch_op(`OPC_SET_WRITE_LATCH, 0, 1'b1);
        latch_op(`OPC_CLR_WRITE_LATCH, 1, 1'b1);
        latch_op(`OPC_CLR_WRITE_LATCH, 0, 1'b0);
        latch_op(`OPC_SET_WRITE_LATCH, 0, 1'b1);
        fork
            core_op(OPK_BULK, 0, 8'h00, 1'b1, 1 << AW);
            begin
                tick(20);
                rd(`OPC_ARRAY_READ, 0, 2, 1'b0, 0);
                rd(`OPC_ID_READ, 0, 1, 1'b0, 0);
            end
        join
        for (int i = 0; i < 4; i++)
        begin
            latch_op(`OPC_SET_WRITE_LATCH, 0, 1'b1);
            core_op(OPK_PROGRAM, AW'(1022 + i), PAT[i], 1'b1, 1);
        end
        latch_op(`OPC_SET_WRITE_LATCH, 0, 1'b1);
        core_op(OPK_PROGRAM, AW'(1023), 8'hF0, 1'b1, 1);
        rd(`OPC_ARRAY_READ, AW'(1022), 5, 1'b1, 0);
        rd(`OPC_FAST_READ, AW'(1023), 3, 1'b1, 5);
        rd(`OPC_ID_READ, 0, 4, 1'b1, 3);
        rd(8'hAB, 0, 2, 1'b0, 0);
        host.cpol = 1'b1;
        latch_op(`OPC_SET_WRITE_LATCH, 0, 1'b1);
        rd(`OPC_ARRAY_READ, AW'(1023), 2, 1'b1, 0);
        host.cpol = 1'b0;
        core_op(OPK_SECTOR, AW'(5), 8'h00, 1'b1, 1 << SW);
        rd(`OPC_ARRAY_READ, AW'(1022), 4, 1'b1, 0);
        latch_op(`OPC_SET_WRITE_LATCH, 0, 1'b1);
        core_op(OPK_NONE, 0, 8'h00, 1'b0, 0);
        chk("latch kept", 1'b1, write_enable_latch);
        latch_op(`OPC_CLR_WRITE_LATCH, 0, 1'b0);
        give_verdict();
    end

endmodule : serial_flash_command_front_end_tb_top
`default_nettype wire

// *** dv/spi_host_model.sv ***
// serial host model driving the flash link in mode 0 or mode 3
`timescale 1ns/10ps
`default_nettype none

module spi_host_model (
    output logic      sclk_out,
    output logic      cs_n_out,
    output logic      si_out,
    input  wire logic so_in,
    input  wire logic so_oe_in
);
    logic cpol = 1'b0;

    // select rises once after start so the device's frame flag is preset
    initial
    begin
        sclk_out = 1'b0;
        si_out   = 1'b0;
        #1;
        cs_n_out = 1'b1;
    end

    // select falls only with the clock at its idle level
    task automatic frame_begin();
        sclk_out = cpol;
        #40;
        cs_n_out = 1'b0;
        #40;
    endtask : frame_begin

    // n bits msb first at 80 ns; so and its enable are taken at each rise
    task automatic xfer(input int n, input logic [7:0] tx, output logic [7:0] rx,
                        output logic [7:0] oe);
        rx = 8'h00;
        oe = 8'h00;
        for (int i = 7; i > 7 - n; i--)
        begin
            sclk_out = 1'b0;
            si_out   = tx[i];
            #40;
            sclk_out = 1'b1;
            rx[i]    = so_in;
            oe[i]    = so_oe_in;
            #40;
        end
    endtask : xfer

    // clock stands still while select is high; released data line inverted
    task automatic frame_end();
        if (cpol == 1'b0)
            sclk_out = 1'b0;
        #40;
        cs_n_out = 1'b1;
        si_out   = ~si_out;
        #200;
    endtask : frame_end

endmodule : spi_host_model
`default_nettype wire

// *** rtl/flash_array.sv ***
// byte array: program port on the core clock, registered read on the link clock
`timescale 1ns/10ps
`default_nettype none

module flash_array #(
    parameter int ADDR_W = 21
) (
    input  wire logic              wclk_in,
    input  wire logic              we_in,
    input  wire logic              erase_in,
    input  wire logic [ADDR_W-1:0] waddr_in,
    input  wire logic [7:0]        wdata_in,
    input  wire logic              rclk_in,
    input  wire logic              re_in,
    input  wire logic [ADDR_W-1:0] raddr_in,
    output logic      [7:0]        rdata_out
);
    import flash_fe_pkg::*;
    `include "flash_fe_params.svh"

    localparam int DEPTH = 1 << ADDR_W;

    logic [7:0] mem_r [0:DEPTH-1];
    logic [7:0] rdata_r;

    // ---------------------------------------------------------------
    // write: erase sets all bits, program can only clear bits
    // ---------------------------------------------------------------
    always_ff @(posedge wclk_in)
    begin
        if (we_in)
        begin
            mem_r[waddr_in] <= erase_in ? `ERASED_BYTE
                                        : (mem_r[waddr_in] & wdata_in);
        end
    end

    always_ff @(posedge rclk_in)
    begin
        if (re_in)
        begin
            rdata_r <= mem_r[raddr_in];
        end
    end

    assign rdata_out = rdata_r;

endmodule : flash_array

`default_nettype wire

// *** rtl/flash_fe_params.svh ***
// constants of the serial flash command front end
`ifndef FLASH_FE_PARAMS_SVH
`define FLASH_FE_PARAMS_SVH

// ---------------------------------------------------------------
// opcodes
// ---------------------------------------------------------------
`define OPC_ARRAY_READ       8'h03
`define OPC_FAST_READ        8'h0B
`define OPC_ID_READ          8'h9F
`define OPC_SET_WRITE_LATCH  8'h06
`define OPC_CLR_WRITE_LATCH  8'h04

// ---------------------------------------------------------------
// array organisation and framing
// ---------------------------------------------------------------
`define ARRAY_ADDR_W         21
`define SECTOR_ADDR_W        16
`define ADDR_BYTES           3'h3
`define ID_BYTES_LAST        2'h2
`define BIT_LAST             3'h7
`define ERASED_BYTE          8'hFF

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define WEL_RST              1'b0
`define CS_SYNC_RST          2'b01

`endif

// *** rtl/flash_fe_pkg.sv ***
// types of the serial flash command front end
package flash_fe_pkg;

    typedef enum logic [2:0] {
        LK_CMD    = 3'b000,
        LK_ADDR   = 3'b001,
        LK_DUMMY  = 3'b010,
        LK_DATA   = 3'b011,
        LK_ID     = 3'b100,
        LK_IGNORE = 3'b101
    } link_state_t;

    typedef enum logic [1:0] {
        CO_IDLE  = 2'b00,
        CO_PROG  = 2'b01,
        CO_ERASE = 2'b10
    } core_state_t;

    typedef enum logic [1:0] {
        OPK_PROGRAM = 2'b00,
        OPK_SECTOR  = 2'b01,
        OPK_BULK    = 2'b10,
        OPK_NONE    = 2'b11
    } op_kind_t;

endpackage : flash_fe_pkg

// *** rtl/serial_flash_command_front_end.sv ***
// serial flash command front end: link framing, reads, write latch, program engine
`timescale 1ns/10ps
`default_nettype none
`include "flash_fe_params.svh"

module serial_flash_command_front_end
    import flash_fe_pkg::*;
#(
    parameter int         ADDR_W    = `ARRAY_ADDR_W,
    parameter int         SECT_W    = `SECTOR_ADDR_W,
    parameter logic [7:0] ID_MAKER  = 8'hA5,  // arbitrary value
    parameter logic [7:0] ID_TYPE   = 8'h3C,  // arbitrary value
    parameter logic [7:0] ID_CAP    = 8'h5A   // arbitrary value
) (
    input  wire logic              clk_in,
    input  wire logic              srst_in,
    input  wire logic              sclk_in,
    input  wire logic              cs_n_in,
    input  wire logic              si_in,
    output logic                   so_out,
    output logic                   so_oe_out,
    input  wire logic              op_req_in,
    input  wire logic [1:0]        op_kind_in,
    input  wire logic [ADDR_W-1:0] op_addr_in,
    input  wire logic [7:0]        op_data_in,
    output logic                   op_ack_out,
    output logic                   op_refused_out,
    output logic                   busy_out,
    output logic                   wel_out
);

    // ---------------------------------------------------------------
    // link domain state
    // ---------------------------------------------------------------
    logic          fresh_r;
    link_state_t   state_r, state_nxt, st_cur;
    logic [2:0]    pos_r, pos_nxt, cnt_cur;
    logic [2:0]    nbytes_r, nbytes_nxt, nbytes_cur;
    logic [7:0]    sh_r, sh_nxt, byte_in;
    logic [7:0]    opcode_r, opcode_nxt;
    logic [23:0]   addr_r, addr_nxt, addr_full;
    logic          fast_r, fast_nxt;
    logic [1:0]    id_idx_r, id_idx_nxt;
    logic          tgl_r, tgl_nxt;
    logic          done_byte;
    logic          rd_en;
    logic [ADDR_W-1:0] rd_addr;
    logic [7:0]    rd_q;
    logic [7:0]    out_byte;
    logic          so_r, so_nxt;
    logic          busy_lk;
    logic          lk_rst_r;
    logic [ADDR_W-1:0] caddr_r;
    logic [7:0]    cdata_r;
    logic          mem_we, mem_erase;

    // ---------------------------------------------------------------
    // frame start: select high presets the fresh flag (mode 0 or 3)
    // ---------------------------------------------------------------
    always_ff @(posedge sclk_in or posedge cs_n_in)
    begin
        if (cs_n_in)
            fresh_r <= 1'b1;
        else
            fresh_r <= 1'b0;
    end

    sync2 #(.WIDTH(1), .RST_VAL(1'b0)) u_busy_sync (
        .clk_in  (sclk_in),
        .srst_in (1'b0),
        .d_in    (busy_out),
        .q_out   (busy_lk)
    );

    always_comb
    begin
        cnt_cur    = fresh_r ? 3'h0 : pos_r;
        st_cur     = fresh_r ? LK_CMD : state_r;
        nbytes_cur = fresh_r ? 3'h0 : nbytes_r;
        byte_in    = {sh_r[6:0], si_in};
        done_byte  = (cnt_cur == `BIT_LAST);
        addr_full  = {addr_r[15:0], byte_in};
        pos_nxt    = cnt_cur + 3'h1;
        sh_nxt     = byte_in;
        state_nxt  = st_cur;
        opcode_nxt = opcode_r;
        addr_nxt   = addr_r;
        fast_nxt   = fast_r;
        id_idx_nxt = id_idx_r;
        // a clock edge while deselected (mode 3 idle level change) is no frame
        tgl_nxt    = (fresh_r && !cs_n_in) ? ~tgl_r : tgl_r;
        nbytes_nxt = nbytes_cur;
        rd_en      = 1'b0;
        rd_addr    = addr_r[ADDR_W-1:0];
        if (done_byte && nbytes_cur != 3'h7)
            nbytes_nxt = nbytes_cur + 3'h1;
        unique case (st_cur)
            LK_CMD:
            begin
                if (done_byte)
                begin
                    opcode_nxt = byte_in;
                    state_nxt  = LK_IGNORE;
                    if (!busy_lk)
                    begin
                        if (byte_in == `OPC_ARRAY_READ || byte_in == `OPC_FAST_READ)
                        begin
                            state_nxt = LK_ADDR;
                            fast_nxt  = (byte_in == `OPC_FAST_READ);
                        end
                        else if (byte_in == `OPC_ID_READ)
                        begin
                            state_nxt  = LK_ID;
                            id_idx_nxt = 2'h0;
                        end
                    end
                end
            end
            LK_ADDR:
            begin
                if (done_byte)
                begin
                    addr_nxt = addr_full;
                    if (nbytes_cur == `ADDR_BYTES)
                    begin
                        if (fast_r)
                            state_nxt = LK_DUMMY;
                        else
                        begin
                            state_nxt = LK_DATA;
                            rd_en     = 1'b1;
                            rd_addr   = addr_full[ADDR_W-1:0];
                        end
                    end
                end
            end
            LK_DUMMY:
            begin
                if (done_byte)
                begin
                    state_nxt = LK_DATA;
                    rd_en     = 1'b1;
                end
            end
            LK_DATA:
            begin
                if (done_byte)
                begin
                    addr_nxt = addr_r + 24'h1;
                    rd_en    = 1'b1;
                    rd_addr  = ADDR_W'(addr_r + 24'h1);
                end
            end
            LK_ID:
            begin
                if (done_byte)
                    id_idx_nxt = (id_idx_r == `ID_BYTES_LAST) ? 2'h0 : id_idx_r + 2'h1;
            end
            LK_IGNORE:
            begin
                state_nxt = LK_IGNORE;
            end
            default:
            begin
                state_nxt = LK_IGNORE;
            end
        endcase
    end

    always_ff @(posedge sclk_in)
    begin
        state_r  <= state_nxt;
        pos_r    <= pos_nxt;
        nbytes_r <= nbytes_nxt;
        sh_r     <= sh_nxt;
        opcode_r <= opcode_nxt;
        addr_r   <= addr_nxt;
        fast_r   <= fast_nxt;
        id_idx_r <= id_idx_nxt;
    end

    // frame toggle starts known so the core's compare is defined after reset
    always_ff @(posedge sclk_in or posedge lk_rst_r)
    begin
        if (lk_rst_r)
            tgl_r <= 1'b0;
        else
            tgl_r <= tgl_nxt;
    end

    flash_array #(.ADDR_W(ADDR_W)) u_array (
        .wclk_in   (clk_in),
        .we_in     (mem_we),
        .erase_in  (mem_erase),
        .waddr_in  (caddr_r),
        .wdata_in  (cdata_r),
        .rclk_in   (sclk_in),
        .re_in     (rd_en),
        .raddr_in  (rd_addr),
        .rdata_out (rd_q)
    );

    // ---------------------------------------------------------------
    // output on falling edges, enabled only in output phases
    // ---------------------------------------------------------------
    always_comb
    begin
        unique case (id_idx_r)
            2'h0:    out_byte = (state_r == LK_ID) ? ID_MAKER : rd_q;
            2'h1:    out_byte = (state_r == LK_ID) ? ID_TYPE : rd_q;
            default: out_byte = (state_r == LK_ID) ? ID_CAP : rd_q;
        endcase
        so_nxt = out_byte[~pos_r];
    end

    always_ff @(negedge sclk_in)
    begin
        so_r <= so_nxt;
    end

    assign so_oe_out = ~fresh_r & (state_r == LK_DATA || state_r == LK_ID);
    assign so_out    = so_oe_out ? so_r : 1'b0;

    // ---------------------------------------------------------------
    // core domain: select rise check, write latch, program engine
    // ---------------------------------------------------------------
    logic [1:0]        cs_tgl_s;
    logic              cs_d_r, cs_d_nxt;
    logic              tgl_seen_r, tgl_seen_nxt;
    logic              wel_r, wel_nxt;
    core_state_t       cstate_r, cstate_nxt;
    logic [ADDR_W-1:0] caddr_nxt;
    logic [7:0]        cdata_nxt;
    logic              bulk_r, bulk_nxt;
    logic              cs_rise, boundary_ok, op_go, erase_end;

    sync2 #(.WIDTH(2), .RST_VAL(`CS_SYNC_RST)) u_cs_sync (
        .clk_in  (clk_in),
        .srst_in (srst_in),
        .d_in    ({tgl_r, cs_n_in}),
        .q_out   (cs_tgl_s)
    );

    always_comb
    begin
        cs_rise     = cs_tgl_s[0] & ~cs_d_r;
        // link registers hold while select is high as long as the link clock does not rise
        boundary_ok = (cs_tgl_s[1] != tgl_seen_r) && (pos_r == 3'h0)
                      && (nbytes_r != 3'h0);
        op_go       = op_req_in && wel_r && (cstate_r == CO_IDLE);
        erase_end   = bulk_r ? (&caddr_r) : (&caddr_r[SECT_W-1:0]);
        mem_we      = (cstate_r != CO_IDLE);
        mem_erase   = (cstate_r == CO_ERASE);
        cs_d_nxt     = cs_tgl_s[0];
        tgl_seen_nxt = cs_rise ? cs_tgl_s[1] : tgl_seen_r;
        wel_nxt      = wel_r;
        cstate_nxt   = cstate_r;
        caddr_nxt    = caddr_r;
        cdata_nxt    = cdata_r;
        bulk_nxt     = bulk_r;
        if (cs_rise && boundary_ok && cstate_r == CO_IDLE)
        begin
            if (opcode_r == `OPC_SET_WRITE_LATCH)
                wel_nxt = 1'b1;
            else if (opcode_r == `OPC_CLR_WRITE_LATCH)
                wel_nxt = 1'b0;
        end
        unique case (cstate_r)
            CO_IDLE:
            begin
                if (op_go && op_kind_t'(op_kind_in) != OPK_NONE)
                begin
                    cdata_nxt = op_data_in;
                    bulk_nxt  = (op_kind_t'(op_kind_in) == OPK_BULK);
                    if (op_kind_t'(op_kind_in) == OPK_PROGRAM)
                    begin
                        cstate_nxt = CO_PROG;
                        caddr_nxt  = op_addr_in;
                    end
                    else
                    begin
                        cstate_nxt = CO_ERASE;
                        caddr_nxt  = (op_kind_t'(op_kind_in) == OPK_BULK) ? '0
                                   : {op_addr_in[ADDR_W-1:SECT_W], {SECT_W{1'b0}}};
                    end
                end
            end
            CO_PROG:
            begin
                cstate_nxt = CO_IDLE;
                wel_nxt    = 1'b0;
            end
            CO_ERASE:
            begin
                caddr_nxt = caddr_r + 1'b1;
                if (erase_end)
                begin
                    cstate_nxt = CO_IDLE;
                    wel_nxt    = 1'b0;
                end
            end
            default:
            begin
                cstate_nxt = CO_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            lk_rst_r   <= 1'b1;
            cs_d_r     <= 1'b1;
            tgl_seen_r <= 1'b0;
            wel_r      <= `WEL_RST;
            cstate_r   <= CO_IDLE;
            caddr_r    <= '0;
            cdata_r    <= 8'h00;
            bulk_r     <= 1'b0;
        end
        else
        begin
            lk_rst_r   <= 1'b0;
            cs_d_r     <= cs_d_nxt;
            tgl_seen_r <= tgl_seen_nxt;
            wel_r      <= wel_nxt;
            cstate_r   <= cstate_nxt;
            caddr_r    <= caddr_nxt;
            cdata_r    <= cdata_nxt;
            bulk_r     <= bulk_nxt;
        end
    end

    assign op_ack_out     = op_go && op_kind_t'(op_kind_in) != OPK_NONE;
    assign op_refused_out = op_req_in && !op_ack_out;
    assign busy_out       = (cstate_r != CO_IDLE);
    assign wel_out        = wel_r;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    a_msb_first_opcode: assert property (@(posedge sclk_in) disable iff (fresh_r)
        (state_r == LK_CMD && pos_r == `BIT_LAST)
        |=> opcode_r == {$past(sh_r[6:0]), $past(si_in)})
        else $error("opcode not shifted msb first");
    a_bit_count_step: assert property (@(posedge sclk_in) disable iff (fresh_r)
        !fresh_r |=> pos_r == 3'($past(pos_r) + 3'h1))
        else $error("bit counter did not advance");
    a_read_busy_refused: assert property (@(posedge sclk_in) disable iff (fresh_r)
        (state_r == LK_CMD && pos_r == `BIT_LAST && busy_lk) |=> state_r == LK_IGNORE)
        else $error("read accepted while busy");
    a_addr_wraps: assert property (@(posedge sclk_in) disable iff (fresh_r)
        (state_r == LK_DATA && pos_r == `BIT_LAST)
        |=> addr_r[ADDR_W-1:0] == ADDR_W'($past(addr_r[ADDR_W-1:0]) + 1'b1))
        else $error("address did not advance after output byte");
    a_id_byte_cycle: assert property (@(posedge sclk_in) disable iff (fresh_r)
        (state_r == LK_ID && pos_r == `BIT_LAST && id_idx_r == `ID_BYTES_LAST)
        |=> id_idx_r == 2'h0 && state_r == LK_ID)
        else $error("identification did not repeat after third byte");
    a_so_hiz_idle: assert property (@(posedge sclk_in)
        (fresh_r || state_r == LK_IGNORE || state_r == LK_CMD) |-> !so_oe_out)
        else $error("output driven outside output phase");
    a_wel_done_clear: assert property (@(posedge clk_in) disable iff (srst_in)
        $fell(busy_out) |-> !wel_out)
        else $error("latch not cleared at completion");
    a_boundary_guard: assert property (@(posedge clk_in) disable iff (srst_in)
        (cs_rise && !boundary_ok && cstate_r == CO_IDLE) |=> wel_r == $past(wel_r))
        else $error("latch changed on off-boundary frame");
    a_busy_on_accept: assert property (@(posedge clk_in) disable iff (srst_in)
        op_ack_out |=> busy_out ##1 (busy_out || !wel_out))
        else $error("busy not raised on accepted operation");
    a_ack_needs_wel: assert property (@(posedge clk_in) disable iff (srst_in)
        op_ack_out |-> wel_r && !busy_out)
        else $error("operation accepted without latch or while busy");

    c_read_data: cover property (@(posedge sclk_in) disable iff (fresh_r)
        state_r == LK_DATA && pos_r == `BIT_LAST);
    c_fast_dummy: cover property (@(posedge sclk_in) disable iff (fresh_r)
        state_r == LK_DUMMY ##8 state_r == LK_DATA);
    c_id_read: cover property (@(posedge sclk_in) disable iff (fresh_r)
        state_r == LK_ID && id_idx_r == `ID_BYTES_LAST);
    c_erase_done: cover property (@(posedge clk_in) disable iff (srst_in)
        cstate_r == CO_ERASE && erase_end);

endmodule : serial_flash_command_front_end

`default_nettype wire

// *** rtl/sync2.sv ***
// two-flop level synchroniser
`timescale 1ns/10ps
`default_nettype none

module sync2 #(
    parameter int          WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             clk_in,
    input  wire logic             srst_in,
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] q_r;
    logic [WIDTH-1:0] q_nxt;

    always_comb
    begin
        meta_nxt = srst_in ? RST_VAL : d_in;
        q_nxt    = srst_in ? RST_VAL : meta_r;
    end

    always_ff @(posedge clk_in)
    begin
        meta_r <= meta_nxt;
        q_r    <= q_nxt;
    end

    assign q_out = q_r;

endmodule : sync2

`default_nettype wire
